// >>> logic/isa_host_pkg.sv
// Constants, types and timing counts shared by the ISA host controller files.
// Assumes a 200 MHz core clock and a device attached to the host pins directly.
package isa_host_pkg;

    // Core clock period in picoseconds.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CLK_MHZ = 200;

    // Least time in ns turned into whole core cycles, rounded up, never below one.
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Reset pulse that the device needs, with the resulting count.
    localparam int RESET_NS = 400;
    localparam int RESET_CYC = ns_to_cyc(RESET_NS);
    // Self configuration time after reset, in microseconds.
    localparam int CAL_US = 10000;
    localparam int CAL_CYC = CAL_US * CLK_MHZ;
    // Bus cycle phases, chosen to suit a bus clock of 8 to 11 MHz.
    localparam int ISA_CLK_MIN_KHZ = 8000;
    localparam int ISA_CLK_MAX_KHZ = 11000;
    localparam int SETUP_NS = 60;
    localparam int STROBE_NS = 250;
    localparam int HOLD_NS = 40;
    localparam int SBHE_NS = 100;
    localparam int SETUP_CYC = ns_to_cyc(SETUP_NS);
    localparam int STROBE_CYC = ns_to_cyc(STROBE_NS);
    localparam int HOLD_CYC = ns_to_cyc(HOLD_NS);
    localparam int SBHE_CYC = ns_to_cyc(SBHE_NS);

    // Device register offsets and I/O window layout.
    localparam logic [15:0] IRQ_SEL_OFS = 16'h0022;
    localparam logic [15:0] DMA_SEL_OFS = 16'h0024;
    localparam logic [15:0] IO_BASE_DEFAULT = 16'h0300;
    localparam logic [3:0] PTR_PORT = 4'ha;
    localparam logic [3:0] DATA_PORT = 4'hc;
    localparam logic [1:0] CFG_LAST_STEP = 2'h3;

    typedef enum logic [2:0] {
        CYC_IO_RD,
        CYC_IO_WR,
        CYC_MEM_RD,
        CYC_MEM_WR,
        CYC_DMA_RD
    } cyc_kind_t;

    // One bus cycle; for I/O kinds only addr[3:0] is used as port offset.
    typedef struct packed {
        cyc_kind_t kind;
        logic [19:0] addr;
        logic [15:0] data;
    } isa_cycle_t;

    // One word read from the device.
    typedef struct packed {
        logic is_dma;
        logic [15:0] data;
    } rd_word_t;

endpackage

// >>> logic/rd_buffer.sv
// Small valid/ready buffer for words read from the device.
// Assumes one clock, a clock enable and an active-low asynchronous reset.
`timescale 1ns/1ps
module rd_buffer #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 2
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_reg[rd_ptr_reg];

    // Pointers wrap at DEPTH so any depth works, not only powers of two.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (i_ce) begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; a word is only read after it was written.
    always_ff @(posedge i_core_clk) begin
        if (i_ce && push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

endmodule // rd_buffer

// >>> logic/isa_host_ctrl.sv
// Host-side controller that drives an ISA Ethernet device through its bus pins.
// Assumes the device pins are synchronous to the core clock and sd is resolved outside.
`timescale 1ns/1ps
module isa_host_ctrl #(
    parameter logic [15:0] IO_BASE = isa_host_pkg::IO_BASE_DEFAULT,
    parameter int CAL_CYC = isa_host_pkg::CAL_CYC,
    parameter int BUF_DEPTH = 2
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [1:0] i_irq_sel,
    input wire logic [1:0] i_dma_sel,
    input wire logic i_dma_en,
    input wire logic i_cmd_valid,
    input wire isa_host_pkg::isa_cycle_t i_cmd,
    output logic o_cmd_ready,
    output logic o_rd_valid,
    output isa_host_pkg::rd_word_t o_rd,
    input wire logic i_rd_ready,
    output logic o_config_done,
    output logic o_irq_pending,
    output logic o_isa_reset,
    output logic [19:0] o_sa,
    output logic o_aen,
    output logic o_sbhe_b,
    output logic o_ior_b,
    output logic o_iow_b,
    output logic o_memr_b,
    output logic o_memw_b,
    output logic o_chipsel_b,
    output logic o_refresh_b,
    output logic [15:0] o_sd_out,
    output logic o_sd_oe,
    input wire logic [15:0] i_sd_in,
    output logic [2:0] o_dack_b,
    input wire logic [3:0] i_irq_req,
    input wire logic [2:0] i_dma_req
);
    typedef enum logic [2:0] {
        ST_RESET, ST_CALWAIT, ST_SBHE, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD
    } state_t;

    state_t state_reg, state_next;
    logic [31:0] cnt_reg, cnt_next;
    isa_host_pkg::isa_cycle_t cyc_reg, cyc_next;
    logic [1:0] cfg_step_reg, cfg_step_next;
    logic cfg_done_reg, cfg_done_next;
    logic [1:0] irq_sel_reg, irq_sel_next;
    logic [1:0] dma_sel_reg, dma_sel_next;
    logic irq_reg;
    isa_host_pkg::isa_cycle_t cfg_cyc;
    logic buf_in_ready;
    logic cnt_done;
    logic in_cycle;
    logic in_strobe;
    logic is_io;
    logic is_mem;
    logic is_wr;
    logic is_rd;
    logic is_dma;
    logic dma_pending;
    logic cmd_take;
    logic rd_push;
    isa_host_pkg::rd_word_t rd_word;

    // Decode of the cycle in progress.
    assign cnt_done = (cnt_reg <= 32'h1);
    assign in_cycle = (state_reg == ST_SETUP) || (state_reg == ST_STROBE) ||
                      (state_reg == ST_HOLD);
    assign in_strobe = (state_reg == ST_STROBE);
    assign is_io = (cyc_reg.kind == isa_host_pkg::CYC_IO_RD) ||
                   (cyc_reg.kind == isa_host_pkg::CYC_IO_WR);
    assign is_mem = (cyc_reg.kind == isa_host_pkg::CYC_MEM_RD) ||
                    (cyc_reg.kind == isa_host_pkg::CYC_MEM_WR);
    assign is_dma = (cyc_reg.kind == isa_host_pkg::CYC_DMA_RD);
    assign is_wr = (cyc_reg.kind == isa_host_pkg::CYC_IO_WR) ||
                   (cyc_reg.kind == isa_host_pkg::CYC_MEM_WR);
    assign is_rd = !is_wr;

    // The four configuration writes go through the pointer and data ports.
    assign cfg_cyc.kind = isa_host_pkg::CYC_IO_WR;
    assign cfg_cyc.addr = {16'h0000, cfg_step_reg[0] ? isa_host_pkg::DATA_PORT :
                                                       isa_host_pkg::PTR_PORT};
    assign cfg_cyc.data = (cfg_step_reg == 2'h0) ? isa_host_pkg::IRQ_SEL_OFS :
                          (cfg_step_reg == 2'h1) ? {14'h0000, irq_sel_reg} :
                          (cfg_step_reg == 2'h2) ? isa_host_pkg::DMA_SEL_OFS :
                                                   {14'h0000, dma_sel_reg};

    // DMA is served before user commands so received frames are not dropped.
    assign dma_pending = cfg_done_reg && i_dma_en && (dma_sel_reg != 2'h3) &&
                         i_dma_req[dma_sel_reg] && buf_in_ready;
    // A read command waits for buffer room so a stalled reader loses no word.
    assign cmd_take = (state_reg == ST_IDLE) && cfg_done_reg && !dma_pending &&
                      i_cmd_valid && (buf_in_ready ||
                      i_cmd.kind == isa_host_pkg::CYC_IO_WR ||
                      i_cmd.kind == isa_host_pkg::CYC_MEM_WR);
    // Transmit commands, lengths and frame data are user writes passed through as is.
    assign o_cmd_ready = cmd_take;
    assign rd_push = in_strobe && cnt_done && is_rd;
    assign rd_word.is_dma = is_dma;
    assign rd_word.data = i_sd_in;

    // Sequencer: reset pulse, calibration wait, high-byte toggle, configuration, cycles.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg - 32'h1;
        cyc_next = cyc_reg;
        cfg_step_next = cfg_step_reg;
        cfg_done_next = cfg_done_reg;
        irq_sel_next = irq_sel_reg;
        dma_sel_next = dma_sel_reg;
        unique case (state_reg)
            ST_RESET: begin
                if (cnt_done) begin
                    state_next = ST_CALWAIT;
                    cnt_next = 32'(CAL_CYC);
                end
            end
            ST_CALWAIT: begin
                if (cnt_done) begin
                    state_next = ST_SBHE;
                    cnt_next = 32'(isa_host_pkg::SBHE_CYC);
                    irq_sel_next = i_irq_sel;
                    dma_sel_next = i_dma_sel;
                end
            end
            ST_SBHE: begin
                if (cnt_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                cnt_next = 32'(isa_host_pkg::SETUP_CYC);
                if (!cfg_done_reg) begin
                    cyc_next = cfg_cyc;
                    state_next = ST_SETUP;
                end else if (dma_pending) begin
                    cyc_next.kind = isa_host_pkg::CYC_DMA_RD;
                    cyc_next.addr = '0;
                    cyc_next.data = '0;
                    state_next = ST_SETUP;
                end else if (cmd_take) begin
                    cyc_next = i_cmd;
                    state_next = ST_SETUP;
                end else begin
                    cnt_next = cnt_reg;
                end
            end
            ST_SETUP: begin
                if (cnt_done) begin
                    state_next = ST_STROBE;
                    cnt_next = 32'(isa_host_pkg::STROBE_CYC);
                end
            end
            ST_STROBE: begin
                if (cnt_done) begin
                    state_next = ST_HOLD;
                    cnt_next = 32'(isa_host_pkg::HOLD_CYC);
                end
            end
            ST_HOLD: begin
                if (cnt_done) begin
                    state_next = ST_IDLE;
                    if (!cfg_done_reg) begin
                        cfg_step_next = cfg_step_reg + 2'h1;
                        cfg_done_next = (cfg_step_reg == isa_host_pkg::CFG_LAST_STEP);
                    end
                end
            end
        endcase
    end

    // State registers; everything freezes while the clock enable is low.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= ST_RESET;
            cnt_reg <= 32'(isa_host_pkg::RESET_CYC);
            cyc_reg <= '0;
            cfg_step_reg <= 2'h0;
            cfg_done_reg <= 1'b0;
            irq_sel_reg <= 2'h0;
            dma_sel_reg <= 2'h3;
        end else if (i_ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cyc_reg <= cyc_next;
            cfg_step_reg <= cfg_step_next;
            cfg_done_reg <= cfg_done_next;
            irq_sel_reg <= irq_sel_next;
            dma_sel_reg <= dma_sel_next;
        end
    end

    // Only the configured interrupt line is watched; the flag follows that line one cycle late.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_reg <= 1'b0;
        end else if (i_ce) begin
            irq_reg <= cfg_done_reg && i_irq_req[irq_sel_reg];
        end
    end

    // Pin decode. I/O cycles keep AEN low; DMA cycles raise it so no slave decodes.
    assign o_isa_reset = (state_reg == ST_RESET);
    assign o_sbhe_b = !(state_reg == ST_SBHE);
    assign o_sa = is_io ? {4'h0, IO_BASE[15:4], cyc_reg.addr[3:0]} : cyc_reg.addr;
    assign o_aen = in_cycle && is_dma;
    assign o_ior_b = !(in_strobe && (cyc_reg.kind == isa_host_pkg::CYC_IO_RD || is_dma));
    assign o_iow_b = !(in_strobe && cyc_reg.kind == isa_host_pkg::CYC_IO_WR);
    assign o_memr_b = !(in_strobe && cyc_reg.kind == isa_host_pkg::CYC_MEM_RD);
    assign o_memw_b = !(in_strobe && cyc_reg.kind == isa_host_pkg::CYC_MEM_WR);
    assign o_chipsel_b = !(in_cycle && is_mem);
    assign o_refresh_b = 1'b1;
    assign o_sd_out = cyc_reg.data;
    assign o_sd_oe = in_cycle && is_wr;
    assign o_dack_b[0] = !(in_cycle && is_dma && dma_sel_reg == 2'h0);
    assign o_dack_b[1] = !(in_cycle && is_dma && dma_sel_reg == 2'h1);
    assign o_dack_b[2] = !(in_cycle && is_dma && dma_sel_reg == 2'h2);
    assign o_config_done = cfg_done_reg;
    assign o_irq_pending = irq_reg;

    // Read words wait here until the user takes them.
    rd_buffer #(
        .WIDTH($bits(isa_host_pkg::rd_word_t)),
        .DEPTH(BUF_DEPTH)
    ) u_rd_buffer (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_in_valid(rd_push && i_ce),
        .o_in_ready(buf_in_ready),
        .i_in_data(rd_word),
        .o_out_valid(o_rd_valid),
        .i_out_ready(i_rd_ready),
        .o_out_data(o_rd)
    );

    // Helper counters for the checks below.
    logic [31:0] rst_len_reg;
    logic [31:0] strb_len_reg;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_len_reg <= '0;
            strb_len_reg <= '0;
        end else if (i_ce) begin
            rst_len_reg <= o_isa_reset ? rst_len_reg + 32'h1 : '0;
            strb_len_reg <= in_strobe ? strb_len_reg + 32'h1 : '0;
        end
    end

    // End of a write strobe, I/O or memory kind.
    sequence s_wr_end;
        $rose(o_iow_b) || $rose(o_memw_b);
    endsequence

    sequence s_mem_rd_start;
        $fell(o_memr_b) && !o_sd_oe;
    endsequence

    AST_RESET_WIDTH: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        $fell(o_isa_reset) |-> (rst_len_reg >= 32'(isa_host_pkg::RESET_CYC)))
        else $error("Reset pulse shorter than required.");

    AST_IO_AEN_LOW: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (!o_iow_b || (!o_ior_b && o_dack_b == 3'h7)) |-> !o_aen)
        else $error("I/O strobe with AEN high.");

    AST_IO_ADDR_MATCH: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        !o_iow_b |-> (o_sa[15:4] == IO_BASE[15:4]))
        else $error("I/O write outside the device window.");

    AST_WR_DATA_HELD: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        s_wr_end |-> o_sd_oe)
        else $error("Write data released before strobe end.");

    AST_MEMR_NO_DRIVE: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        s_mem_rd_start |-> !o_sd_oe [*4])
        else $error("Host drives data during memory read.");

    AST_STROBE_LEN: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_ce && in_strobe && cnt_done) |=>
        (strb_len_reg == 32'(isa_host_pkg::STROBE_CYC)))
        else $error("Strobe width differs from the set length.");

    AST_DACK_SELECTED: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (o_dack_b != 3'h7) |-> ($countones(~o_dack_b) == 1 && !o_dack_b[dma_sel_reg]))
        else $error("Acknowledge on an unselected DMA channel.");

    AST_NO_CMD_BEFORE_CFG: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        !cfg_done_reg |-> !o_cmd_ready)
        else $error("User command taken before configuration.");

    AST_IRQ_FOLLOWS_LINE: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        ($past(i_ce) && $past(cfg_done_reg)) |->
        (o_irq_pending == $past(i_irq_req[irq_sel_reg])))
        else $error("Interrupt pending does not follow the selected line.");

    AST_READ_HAS_ROOM: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_ce && rd_push) |-> buf_in_ready)
        else $error("Read word captured with no buffer room.");

endmodule // isa_host_ctrl

// >>> testbench/isa_dev_model.sv
// Behavioural model of the network device that sits behind the controller's ISA pins.
// Assumes pins synchronous to the core clock and a data bus resolved by the bench.
`timescale 1ns/1ps
module isa_dev_model #(
    parameter logic [15:0] IO_BASE = 16'h0300
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [19:0] i_sa,
    input wire logic i_aen,
    input wire logic i_ior_b,
    input wire logic i_iow_b,
    input wire logic i_memr_b,
    input wire logic i_memw_b,
    input wire logic i_chipsel_b,
    input wire logic i_refresh_b,
    input wire logic i_sbhe_b,
    input wire logic [15:0] i_sd,
    input wire logic [2:0] i_dack_b,
    input wire logic i_evt,
    input wire logic [1:0] i_add_frames,
    output logic [15:0] o_sd,
    output wire logic [3:0] o_irq_line,
    output wire logic [2:0] o_dma_line
);
    logic [15:0] ptr, irq_num, dma_num, last, dseq, rd_val;
    logic [15:0] mem [0:7];
    logic [1:0] frames;
    logic q, irq_hi, ior_q, iow_q, memw_q, sbhe_q, sbhe_ok;
    int rst_cnt = 0;
    int dack_err = 0;
    // Strobes count only with refresh high; I/O also needs aen low and a base match.
    // I/O and memory accesses are ignored until the high-byte enable has toggled once since reset; DMA reads are not.
    wire io_hit = sbhe_ok && !i_aen && i_sa[15:4] == IO_BASE[15:4] &&
                  i_refresh_b;
    wire mem_hit = sbhe_ok && !i_chipsel_b && i_refresh_b;
    wire dma_hit = i_refresh_b && dma_num < 16'h3 && !i_dack_b[dma_num[1:0]];
    wire ior_end = i_ior_b && !ior_q;
    wire iow_end = i_iow_b && !iow_q && io_hit;
    wire dma_end = ior_end && dma_hit;
    wire wr_c = iow_end && i_sa[3:0] == 4'hc;
    // Port a holds the pointer, port 8 the status queue, other ports the pointed register.
    assign rd_val = (i_sa[3:0] == 4'ha) ? ptr : (i_sa[3:0] == 4'h8) ? {13'h0, q, 2'h0} :
                    (ptr == 16'h0022) ? irq_num : (ptr == 16'h0024) ? dma_num : 16'h0;
    // A released bus shows the inverse of its last value, so a stale word cannot pass.
    assign o_sd = (dma_hit && !i_ior_b) ? dseq : (io_hit && !i_ior_b) ? rd_val :
                  (mem_hit && !i_memr_b) ? mem[i_sa[3:1]] : ~last;
    // Only the selected request lines are driven; all of them float after reset.
    for (genvar k = 0; k < 4; k++) begin : g_irq
        assign o_irq_line[k] = (!i_reset && irq_num == k) ? irq_hi : 1'bz;
    end
    for (genvar k = 0; k < 3; k++) begin : g_dma
        assign o_dma_line[k] = (!i_reset && dma_num == k) ? (frames != 2'h0) : 1'bz;
    end
    // Cycles take effect when their strobe is released, while address and data still stand.
    always @(posedge i_core_clk) begin
        ior_q <= i_ior_b;
        iow_q <= i_iow_b;
        memw_q <= i_memw_b;
        sbhe_q <= i_sbhe_b;
        last <= o_sd;
        if ((~i_dack_b & ~(3'h1 << dma_num[1:0])) != 3'h0)
            dack_err <= dack_err + 1;
        if (i_reset) begin
            rst_cnt <= rst_cnt + 1;
            ptr <= 16'h3000;
            irq_num <= 16'h0004;
            dma_num <= 16'h0003;
            dseq <= 16'hd000;
            {q, irq_hi, frames} <= '0;
            sbhe_ok <= 1'b0;
        end else begin
            frames <= frames + i_add_frames - {1'b0, dma_end};
            if (i_sbhe_b && !sbhe_q)
                sbhe_ok <= 1'b1;
            if (dma_end)
                dseq <= dseq + 16'h1;
            if (iow_end && i_sa[3:0] == 4'ha)
                ptr <= i_sd;
            if (wr_c && ptr == 16'h0022)
                irq_num <= i_sd;
            if (wr_c && ptr == 16'h0024)
                dma_num <= i_sd;
            if (i_memw_b && !memw_q && mem_hit)
                mem[i_sa[3:1]] <= i_sd;
            if (i_evt) begin
                q <= 1'b1;
                irq_hi <= 1'b1;
            end else if (ior_end && io_hit && i_sa[3:0] == 4'h8) begin
                q <= 1'b0;
                irq_hi <= q;
            end
        end
    end
endmodule // isa_dev_model

// >>> testbench/test_isa_host_ctrl.sv
// Self-checking bench for the ISA host controller against the device model.
// Assumes a short calibration count and the model in isa_dev_model.
`timescale 1ns/1ps
module test_isa_host_ctrl;
    typedef struct packed {logic [2:0] k; logic [19:0] a; logic [15:0] d; logic [16:0] e;} row_t;
    logic clk = 0, i_rst_b = 0, i_cmd_valid = 1, i_rd_ready = 1, i_dma_en = 0, evt = 0;
    logic [1:0] i_irq_sel = 2'h2, i_dma_sel = 2'h1, add = 2'h0;
    isa_host_pkg::isa_cycle_t i_cmd = '{isa_host_pkg::CYC_IO_RD, 20'h0000a, 16'h0};
    isa_host_pkg::rd_word_t o_rd;
    isa_host_pkg::rd_word_t got [$];
    logic o_cmd_ready, o_rd_valid, o_config_done, o_irq_pending, o_isa_reset, o_aen, o_sbhe_b;
    logic ior_b, iow_b, memr_b, memw_b, cs_b, rf_b, sd_oe;
    logic [19:0] sa;
    logic [15:0] sd_out, dev_sd, sd_w;
    logic [2:0] dack_b, dma_in;
    logic [3:0] irq_in;
    wire [3:0] irq_w;
    wire [2:0] dma_w;
    int fail_count = 0, n_compared = 0, n = 0, early = 0;
    // Kind, address, data and, for reads, the expected {is_dma, data}.
    row_t rows [7] = '{'{3'h0, 20'h0000c, 16'h0, 17'h00001},
        '{3'h1, 20'h0000a, 16'h0022, 17'h0}, '{3'h0, 20'h0000c, 16'h0, 17'h00002},
        '{3'h3, 20'hd0006, 16'hbeef, 17'h0}, '{3'h3, 20'hd000e, 16'h1234, 17'h0},
        '{3'h2, 20'hd0006, 16'h0, 17'h0beef}, '{3'h2, 20'hd000e, 16'h0, 17'h01234}};
    // Host word wins while it drives; floating request lines read as low.
    assign sd_w = sd_oe ? sd_out : dev_sd;
    assign irq_in = {irq_w[3] === 1'b1, irq_w[2] === 1'b1, irq_w[1] === 1'b1, irq_w[0] === 1'b1};
    assign dma_in = {dma_w[2] === 1'b1, dma_w[1] === 1'b1, dma_w[0] === 1'b1};
    initial begin
        forever #2.5 clk = ~clk;
    end
    isa_host_ctrl #(.CAL_CYC(200)) u_dut (
        .i_core_clk(clk), .i_rst_b, .i_ce(1'b1), .i_irq_sel, .i_dma_sel, .i_dma_en, .i_cmd_valid,
        .i_cmd, .o_cmd_ready, .o_rd_valid, .o_rd, .i_rd_ready, .o_config_done, .o_irq_pending,
        .o_isa_reset, .o_sa(sa), .o_aen, .o_sbhe_b, .o_ior_b(ior_b), .o_iow_b(iow_b),
        .o_memr_b(memr_b), .o_memw_b(memw_b), .o_chipsel_b(cs_b), .o_refresh_b(rf_b),
        .o_sd_out(sd_out), .o_sd_oe(sd_oe), .i_sd_in(sd_w), .o_dack_b(dack_b),
        .i_irq_req(irq_in), .i_dma_req(dma_in));
    isa_dev_model u_dev (.i_core_clk(clk), .i_reset(o_isa_reset), .i_sa(sa), .i_aen(o_aen),
        .i_ior_b(ior_b), .i_iow_b(iow_b), .i_memr_b(memr_b), .i_memw_b(memw_b),
        .i_chipsel_b(cs_b), .i_refresh_b(rf_b), .i_sbhe_b(o_sbhe_b), .i_sd(sd_w),
        .i_dack_b(dack_b), .i_evt(evt), .i_add_frames(add), .o_sd(dev_sd), .o_irq_line(irq_w),
        .o_dma_line(dma_w));
    // Every word the bench accepts is queued for in-order comparison.
    always @(posedge clk)
        if (o_rd_valid === 1'b1 && i_rd_ready === 1'b1) got.push_back(o_rd);
    task automatic check(input logic [16:0] g, input logic [16:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Holds the request until it is taken, then lets one edge pass with it low.
    task automatic issue(input logic [2:0] k, input logic [19:0] a, input logic [15:0] d);
        int w;
        w = 0;
        i_cmd_valid <= 1'b1;
        i_cmd <= '{isa_host_pkg::cyc_kind_t'(k), a, d};
        do begin
            @(posedge clk);
            w++;
        end while (o_cmd_ready !== 1'b1 && w < 2000);
        if (w >= 2000) fail_count++;
        i_cmd_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pop_check(input logic [16:0] e);
        int w;
        w = 0;
        while (got.size() == 0 && w < 500) begin
            @(posedge clk);
            w++;
        end
        check((got.size() > 0) ? got.pop_front() : ~e, e);
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Reset, a command offered before configuration, table rows, then the awkward cases.
    initial begin
        repeat (4) @(posedge clk);
        i_rst_b <= 1'b1;
        while (o_config_done !== 1'b1 && n < 5000) begin
            @(posedge clk);
            if (o_cmd_ready === 1'b1 && o_config_done !== 1'b1) early++;
            n++;
        end
        // The early read is taken at the first idle edge after configuration, so drop it now.
        i_cmd_valid <= 1'b0;
        check(17'(early), 17'h0);
        check({16'h0, u_dev.rst_cnt >= isa_host_pkg::RESET_CYC}, 17'h1);
        pop_check(17'h00024);
        foreach (rows[i]) begin
            issue(rows[i].k, rows[i].a, rows[i].d);
            if (rows[i].k == 3'h0 || rows[i].k == 3'h2) pop_check(rows[i].e);
        end
        // A full buffer must refuse further reads while the receiver stalls.
        i_rd_ready <= 1'b0;
        issue(3'h0, 20'h0000a, 16'h0);
        issue(3'h0, 20'h0000a, 16'h0);
        i_cmd_valid <= 1'b1;
        early = 0;
        repeat (150) begin
            @(posedge clk);
            if (o_cmd_ready === 1'b1) early++;
        end
        check(17'(early), 17'h0);
        i_rd_ready <= 1'b1;
        issue(3'h0, 20'h0000a, 16'h0);
        repeat (3) pop_check(17'h00022);
        // Two received frames are moved by DMA, after which the request drops.
        i_dma_en <= 1'b1;
        add <= 2'h2;
        @(posedge clk);
        add <= 2'h0;
        pop_check(17'h1d000);
        pop_check(17'h1d001);
        n = 0;
        while (dma_in !== 3'h0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        check({14'h0, dma_in}, 17'h0);
        check(17'(u_dev.dack_err), 17'h0);
        // The line stays high until a status read returns zero.
        evt <= 1'b1;
        @(posedge clk);
        evt <= 1'b0;
        repeat (3) @(posedge clk);
        check({16'h0, o_irq_pending}, 17'h1);
        issue(3'h0, 20'h00008, 16'h0);
        pop_check(17'h00004);
        check({16'h0, o_irq_pending}, 17'h1);
        issue(3'h0, 20'h00008, 16'h0);
        pop_check(17'h00000);
        repeat (3) @(posedge clk);
        check({16'h0, o_irq_pending}, 17'h0);
        tally_and_finish();
    end
    // The whole run needs under two thousand cycles; this margin only catches a hang.
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
endmodule // test_isa_host_ctrl
